//--- diag_pkg.sv
/*
 * constants, field layouts and carrier types for the led driver diagnostic flag block.
 * assumes a single 100 mhz system clock and analog comparators delivered as synchronous levels.
 */
// Summary of operation
// - latch thermal warning flag in status two when temperature exceeds programmable threshold
// - thermal warning threshold resets to setting code 179
// - thermal shutdown disables booster and both buck channels
// - shutdown ends by itself once temperature falls below the warning level
// - latched shutdown indication holds until a status read clears it
// - shutdown threshold is a fixed trimmed value, not software writable
// - any serial error sets a latched error bit in status two
// - per channel, on-time counter overflow after 50 us latches open-string flag
// - open-string detection never disables the buck channel
// - per channel, short flag follows comparator: output voltage below minimum
// - a short on a switching channel forces fixed off-time
// - short detection works with channel off; fixed off-time then irrelevant
// - overcurrent latches channel flag in status one and disables that channel
// - per channel live running flags regardless of commands
// - live booster running flag separate from booster enable
// - booster overvoltage latches flag in status one
// - control pin levels mirrored live into status two
// - power-on reset flag in status three set only at power-on reset
// - power-on reset flag is bit 5 of status three, reads one after power-up
package diag_pkg;

    localparam int channel_count = 2;
    localparam int temp_width = 8;
    localparam int status_width = 10;

    localparam logic [7:0] warn_threshold_reset = 8'hb3;
    localparam logic [7:0] shutdown_threshold_trim = 8'hc8;

    localparam int clk_mhz = 100;
    localparam int open_detect_on_time_us = 50;
    localparam int open_detect_cycles = open_detect_on_time_us * clk_mhz;

    // status one fields
    localparam int st1_open_lsb = 0;
    localparam int st1_short_lsb = 2;
    localparam int st1_overcurrent_lsb = 4;
    localparam int st1_running_lsb = 6;
    localparam int st1_boost_status_bit = 8;
    localparam int st1_booster_overvoltage_flag_bit = 9;
    // status two fields
    localparam int st2_thermal_warn_bit = 0;
    localparam int st2_shutdown_live_bit = 1;
    localparam int st2_shutdown_latched_bit = 2;
    localparam int st2_serial_error_bit = 3;
    localparam int st2_pin_level_lsb = 4;
    // status three fields
    localparam int st3_power_on_reset_bit = 5;

    typedef struct packed {
        logic [1:0] switch_on;
        logic [1:0] output_low;
        logic [1:0] overcurrent;
        logic [1:0] control_pin;
        logic booster_running;
        logic booster_overvoltage;
        logic serial_error;
    } diag_events_type;

    typedef struct packed {
        logic [1:0] channel_enable;
        logic [1:0] fixed_off_time;
        logic booster_enable;
    } power_control_type;

    typedef struct packed {
        logic read1;
        logic read2;
        logic read3;
    } status_read_type;

endpackage : diag_pkg

//--- open_timer.sv
/*
 * on-time counter for one buck channel; pulses once on overflow.
 * assumes the switch-on level is synchronous to the clock.
 */
`timescale 1ns/1ps
module open_timer #(
    parameter int cycles = diag_pkg::open_detect_cycles
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // channel activity
    input wire logic i_active,
    // overflow event
    output logic o_overflow
);

    localparam int cnt_width = $clog2(cycles + 1);

    initial begin
        if (cycles < 1) begin
            $error("open_timer: cycles must be at least one");
        end
    end

    logic [cnt_width-1:0] count;

    // count saturates so a long on-time flags once per activation
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
        end else if (!i_active) begin
            count <= '0;
        end else if (count != cnt_width'(cycles)) begin
            count <= count + cnt_width'(1);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_overflow <= 1'b0;
        end else begin
            o_overflow <= i_active && (count == cnt_width'(cycles - 1));
        end
    end

endmodule : open_timer

//--- thermal_monitor.sv
/*
 * thermal warning and shutdown comparison against a temperature code.
 * assumes the temperature code is a synchronous sample from a converter.
 */
`timescale 1ns/1ps
module thermal_monitor (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // temperature and programmable threshold
    input wire logic [7:0] i_temp_code,
    input wire logic [7:0] i_warn_threshold,
    // results
    output logic o_over_warn,
    output logic o_shutdown
);

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_over_warn <= 1'b0;
        end else begin
            o_over_warn <= i_temp_code > i_warn_threshold;
        end
    end

    // hysteresis: enter at the trimmed level, leave below the warning level
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_shutdown <= 1'b0;
        end else if (i_temp_code > diag_pkg::shutdown_threshold_trim) begin
            o_shutdown <= 1'b1;
        end else if (i_temp_code < i_warn_threshold) begin
            o_shutdown <= 1'b0;
        end
    end

endmodule : thermal_monitor

//--- diag_flags.sv
/*
 * diagnostic flag block: latches and live flags, protective shutdown, status words.
 * assumes the serial interface decodes register writes and read strobes elsewhere.
 */
`timescale 1ns/1ps
module diag_flags #(
    parameter int open_cycles = diag_pkg::open_detect_cycles
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // thermal
    input wire logic [7:0] i_temp_code,
    input wire logic i_warn_write,
    input wire logic [7:0] i_warn_value,
    // analog and pin events
    input wire diag_pkg::diag_events_type i_events,
    // commands
    input wire logic [1:0] i_channel_cmd,
    input wire logic i_booster_cmd,
    // status read strobes, one cycle each
    input wire diag_pkg::status_read_type i_read,
    // status words
    output logic [9:0] o_status1,
    output logic [9:0] o_status2,
    output logic [9:0] o_status3,
    output logic [7:0] o_warn_threshold,
    // power stage control
    output diag_pkg::power_control_type o_power
);

    initial begin
        if (open_cycles < 1) begin
            $error("diag_flags: open_cycles must be at least one");
        end
    end

    logic over_warn;
    logic shutdown;
    logic [1:0] overflow;
    logic thermal_warn_flag;
    logic thermal_shutdown_flag;
    logic serial_error_flag;
    logic [1:0] open_string_flag;
    logic [1:0] overcurrent_flag;
    logic booster_overvoltage_flag;
    logic power_on_reset_flag;
    logic [1:0] oc_lockout;

    // latch with set winning over the read clear
    function automatic logic latch(input logic cur, input logic set, input logic clr);
        latch = set | (cur & ~clr);
    endfunction : latch

    // a pending set shows through so a read never misses it
    function automatic logic [1:0] latch_view(input logic [1:0] cur, input logic [1:0] set);
        latch_view = cur | set;
    endfunction : latch_view

    ////////////////////////////////////////////////////////////////////////
    // thermal

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_warn_threshold <= diag_pkg::warn_threshold_reset;
        end else if (i_warn_write) begin
            o_warn_threshold <= i_warn_value;
        end
    end

    thermal_monitor u_thermal (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_temp_code(i_temp_code),
        .i_warn_threshold(o_warn_threshold),
        .o_over_warn(over_warn),
        .o_shutdown(shutdown)
    );

    ////////////////////////////////////////////////////////////////////////
    // open string timers

    for (genvar ch = 0; ch < 2; ch++) begin : g_open
        open_timer #(.cycles(open_cycles)) u_timer (
            .i_clk_sys(i_clk_sys),
            .i_reset_n(i_reset_n),
            .i_active(i_events.switch_on[ch]),
            .o_overflow(overflow[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // latched flags

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            thermal_warn_flag <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
            serial_error_flag <= 1'b0;
        end else begin
            thermal_warn_flag <= latch(thermal_warn_flag, over_warn, i_read.read2);
            thermal_shutdown_flag <= latch(thermal_shutdown_flag, shutdown, i_read.read2);
            serial_error_flag <= latch(serial_error_flag, i_events.serial_error, i_read.read2);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            open_string_flag <= 2'h0;
            overcurrent_flag <= 2'h0;
            booster_overvoltage_flag <= 1'b0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                open_string_flag[ch] <= latch(open_string_flag[ch], overflow[ch], i_read.read1);
                overcurrent_flag[ch] <= latch(overcurrent_flag[ch], i_events.overcurrent[ch], i_read.read1);
            end
            booster_overvoltage_flag <= latch(booster_overvoltage_flag, i_events.booster_overvoltage,
                                              i_read.read1);
        end
    end

    // only the asynchronous power-on reset sets this; reading status three clears it
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            power_on_reset_flag <= 1'b1;
        end else if (i_read.read3) begin
            power_on_reset_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection

    // overcurrent keeps the channel off until the command is withdrawn and reissued
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            oc_lockout <= 2'h0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (i_events.overcurrent[ch]) begin
                    oc_lockout[ch] <= 1'b1;
                end else if (!i_channel_cmd[ch]) begin
                    oc_lockout[ch] <= 1'b0;
                end
            end
        end
    end

    // open strings deliberately do not enter these terms
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_power <= '0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                o_power.channel_enable[ch] <= i_channel_cmd[ch] && !shutdown
                    && !oc_lockout[ch] && !i_events.overcurrent[ch];
                o_power.fixed_off_time[ch] <= i_events.output_low[ch]
                    && i_events.switch_on[ch];
            end
            o_power.booster_enable <= i_booster_cmd && !shutdown;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status words

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_status1 <= '0;
        end else begin
            o_status1 <= '0;
            o_status1[diag_pkg::st1_open_lsb +: 2] <= latch_view(open_string_flag, overflow);
            o_status1[diag_pkg::st1_short_lsb +: 2] <= i_events.output_low;
            o_status1[diag_pkg::st1_overcurrent_lsb +: 2] <= latch_view(overcurrent_flag, i_events.overcurrent);
            o_status1[diag_pkg::st1_running_lsb +: 2] <= i_events.switch_on;
            o_status1[diag_pkg::st1_boost_status_bit] <= i_events.booster_running;
            o_status1[diag_pkg::st1_booster_overvoltage_flag_bit] <= booster_overvoltage_flag | i_events.booster_overvoltage;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_status2 <= '0;
        end else begin
            o_status2 <= '0;
            o_status2[diag_pkg::st2_thermal_warn_bit] <= thermal_warn_flag | over_warn;
            o_status2[diag_pkg::st2_shutdown_live_bit] <= shutdown;
            o_status2[diag_pkg::st2_shutdown_latched_bit] <= thermal_shutdown_flag | shutdown;
            o_status2[diag_pkg::st2_serial_error_bit] <= serial_error_flag | i_events.serial_error;
            o_status2[diag_pkg::st2_pin_level_lsb +: 2] <= i_events.control_pin;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_status3 <= '0;
        end else begin
            o_status3 <= '0;
            o_status3[diag_pkg::st3_power_on_reset_bit] <= power_on_reset_flag;
        end
    end

endmodule : diag_flags

//--- diag_host_model.sv
/* host side model: turns a poll request into a one-cycle status read strobe.
   assumes the bench raises one poll bit for one cycle per read. */
`timescale 1ns/1ps
module diag_host_model (
    // clock
    input wire logic i_clk_sys,
    // poll request: read1, read2, read3
    input wire logic [2:0] i_poll,
    // read strobes to the flag block
    output diag_pkg::status_read_type o_read
);
    // strobe launched just after the edge, held one full cycle
    always_ff @(posedge i_clk_sys) begin
        o_read <= i_poll;
    end
endmodule : diag_host_model

//--- diag_flags_chk.sv
/* assertions on the diagnostic flag block ports.
   assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
module diag_flags_chk #(
    parameter int open_cycles = diag_pkg::open_detect_cycles
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // inputs
    input wire diag_pkg::diag_events_type i_events,
    input wire diag_pkg::status_read_type i_read,
    // outputs
    input wire logic [9:0] o_status1,
    input wire logic [9:0] o_status2,
    input wire logic [9:0] o_status3,
    input wire logic [7:0] o_warn_threshold,
    input wire diag_pkg::power_control_type o_power
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    ////////////////////////////////////////
    // either channel: the hit channel latches its flag and drops its enable
    oc_latch_a: assert property (|i_events.overcurrent |=>
        (o_status1[5:4] & $past(i_events.overcurrent)) == $past(i_events.overcurrent)
        && (o_power.channel_enable & $past(i_events.overcurrent)) == 2'h0)
        else $error("overcurrent not latched");
    ov_latch_a: assert property (i_events.booster_overvoltage |=> o_status1[9])
        else $error("overvoltage not latched");
    serial_latch_a: assert property (i_events.serial_error |=> o_status2[3])
        else $error("serial error not latched");
    // a read clears two edges later, so both past cycles are excluded
    ov_hold_a: assert property (o_status1[9] && !i_read.read1 && !$past(i_read.read1)
        && !$past(i_read.read1, 2) |=> o_status1[9])
        else $error("latched flag dropped");
    short_live_a: assert property (1'h1 |=> o_status1[3:2] == $past(i_events.output_low))
        else $error("short flag wrong");
    run_live_a: assert property (1'h1 |=> o_status1[8:6] == {$past(i_events.booster_running),
        $past(i_events.switch_on)})
        else $error("running flags wrong");
    pin_live_a: assert property (1'h1 |=> o_status2[5:4] == $past(i_events.control_pin))
        else $error("pin level wrong");
    off_time_a: assert property (1'h1 |=>
        o_power.fixed_off_time == $past(i_events.output_low & i_events.switch_on))
        else $error("fixed off time wrong");
    shutdown_off_a: assert property (o_status2[1] |->
        o_power.channel_enable == 2'h0 && !o_power.booster_enable)
        else $error("outputs on in shutdown");
    warn_reset_a: assert property ($rose(i_reset_n) |-> o_warn_threshold == diag_pkg::warn_threshold_reset)
        else $error("warning threshold reset wrong");
    por_flag_a: assert property ($rose(i_reset_n) |=> o_status3[diag_pkg::st3_power_on_reset_bit])
        else $error("power-on flag missing");
    cover property (o_status1[0]);
    cover property ($fell(o_status2[1]));
    cover property (i_read.read2 && o_status2[2]);
endmodule : diag_flags_chk
bind diag_flags diag_flags_chk #(.open_cycles(open_cycles)) i_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_events(i_events), .i_read(i_read), .o_status1(o_status1), .o_status2(o_status2),
    .o_status3(o_status3), .o_warn_threshold(o_warn_threshold), .o_power(o_power));

//--- test_diag_flags.sv
/* self-checking bench for the diagnostic flag block.
   assumes a 100 mhz clock; open timer shortened to 8 cycles. */
`timescale 1ns/1ps
module test_diag_flags;
    logic i_clk_sys = 1'h0;
    logic i_reset_n = 1'h0;
    logic [7:0] i_temp_code = 8'h20;
    logic i_warn_write = 1'h0;
    logic [7:0] i_warn_value = 8'h00;
    diag_pkg::diag_events_type i_events = 11'h000;
    logic [1:0] i_channel_cmd = 2'h0;
    logic i_booster_cmd = 1'h0;
    logic [2:0] poll = 3'h0;
    diag_pkg::status_read_type i_read;
    logic [9:0] o_status1;
    logic [9:0] o_status2;
    logic [9:0] o_status3;
    logic [7:0] o_warn_threshold;
    diag_pkg::power_control_type o_power;
    int fails = 0;
    int compares = 0;
    int n;
    ////////////////////////////////////////
    diag_flags #(.open_cycles(8)) i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_temp_code(i_temp_code),
        .i_warn_write(i_warn_write), .i_warn_value(i_warn_value), .i_events(i_events),
        .i_channel_cmd(i_channel_cmd), .i_booster_cmd(i_booster_cmd), .i_read(i_read), .o_status1(o_status1),
        .o_status2(o_status2), .o_status3(o_status3), .o_warn_threshold(o_warn_threshold), .o_power(o_power));
    diag_host_model i_host (.i_clk_sys(i_clk_sys), .i_poll(poll), .o_read(i_read));
    always #5 i_clk_sys = ~i_clk_sys;
    ////////////////////////////////////////
    task summarize;
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task check(input logic [9:0] seen, input logic [9:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // inputs change 1 ns after the edge, away from sampling
    task tick(input int cnt);
        repeat (cnt) @(posedge i_clk_sys);
        #1;
    endtask : tick
    task read_status(input logic [2:0] which);
        poll = which;
        tick(1);
        poll = 3'h0;
        tick(3);
    endtask : read_status
    ////////////////////////////////////////
    initial begin
        tick(10);
        i_reset_n = 1'h1;
        tick(1);
        check(o_warn_threshold, 10'h0b3);
        check(o_status3, 10'h020);
        for (n = 0; n < 4; n++) begin
            i_events.switch_on = n[1:0];
            i_events.output_low = n[1:0] ^ 2'h2;
            i_events.control_pin = n[1:0] ^ 2'h1;
            i_events.booster_running = n[0];
            tick(1);
            check(o_status1[8:6], {n[0], n[1:0]});
            check(o_status1[3:2], n[1:0] ^ 2'h2);
            check(o_status2[5:4], n[1:0] ^ 2'h1);
            check(o_power.fixed_off_time, n[1:0] & (n[1:0] ^ 2'h2));
        end
        i_channel_cmd = 2'h3;
        i_booster_cmd = 1'h1;
        i_events.switch_on = 2'h1;
        for (n = 0; n < 20 && o_status1[0] !== 1'h1; n++) tick(1);
        check(o_status1[1:0], 10'h001);
        if (n == 20) summarize();
        check(o_power.channel_enable, 10'h003);
        i_events.switch_on = 2'h0;
        i_events.overcurrent = 2'h2;
        i_events.booster_overvoltage = 1'h1;
        i_events.serial_error = 1'h1;
        tick(1);
        i_events.overcurrent = 2'h0;
        i_events.booster_overvoltage = 1'h0;
        i_events.serial_error = 1'h0;
        check(o_power.channel_enable, 10'h001);
        tick(4);
        check({o_status1[9], o_status1[5:4], o_status2[3]}, 10'h00d);
        read_status(3'h4);
        check({o_status1[9], o_status1[5:4], o_status1[1:0], o_status2[3]}, 10'h001);
        read_status(3'h2);
        check(o_status2[3], 10'h000);
        i_channel_cmd = 2'h1;
        tick(1);
        i_channel_cmd = 2'h3;
        tick(2);
        check(o_power.channel_enable, 10'h003);
        i_warn_value = 8'h80;
        i_warn_write = 1'h1;
        tick(1);
        i_warn_write = 1'h0;
        i_temp_code = 8'h81;
        tick(2);
        check({o_warn_threshold, o_status2[0]}, 10'h101);
        i_temp_code = 8'hc9;
        tick(2);
        check({o_status2[2:1], o_power.channel_enable, o_power.booster_enable}, 10'h018);
        i_temp_code = 8'h90;
        tick(3);
        check(o_status2[1], 10'h001);
        i_temp_code = 8'h7f;
        tick(3);
        check({o_status2[2:1], o_power.channel_enable, o_power.booster_enable}, 10'h017);
        read_status(3'h2);
        check(o_status2[2:0], 10'h000);
        i_warn_value = 8'hff;
        i_warn_write = 1'h1;
        tick(1);
        i_warn_write = 1'h0;
        i_temp_code = 8'hc9;
        tick(3);
        check(o_status2[1], 10'h001);
        i_temp_code = 8'h20;
        read_status(3'h1);
        tick(20);
        check(o_status3, 10'h000);
        // a second power-on reset in mid-run must raise the flag and restore the threshold
        i_reset_n = 1'h0;
        tick(2);
        check(o_warn_threshold, 10'h0b3);
        check(o_status2, 10'h000);
        i_reset_n = 1'h1;
        tick(1);
        check(o_status3, 10'h020);
        check(o_warn_threshold, 10'h0b3);
        summarize();
    end
endmodule : test_diag_flags
